// ### logic/dsd_pkg.sv
// Purpose: Shared constants for the slave diagnostic responder and its master.
// Assumes: One clock at 125 MHz for both ends.
// Notes: Octet numbers below count from one inside the frame.
`default_nettype none
package dsd_pkg;
    // Fixed standard header and the identifier block behind it.
    localparam int HDR_LEN = 6;
    localparam int MOD_COUNT = 1;
    localparam int ID_OCTETS = (MOD_COUNT + 7) / 8;
    localparam int ID_LEN_MIN = 2;
    localparam int ID_LEN_MAX = 32;
    localparam int ID_FLAG_MAX = ID_LEN_MAX - 1;
    localparam int ID_SENT = (ID_OCTETS > ID_FLAG_MAX) ? ID_FLAG_MAX : ID_OCTETS;
    localparam int FRAME_LEN = HDR_LEN + 1 + ID_SENT;
    localparam logic [5:0] ID_BLOCK_LEN = 6'(1 + ID_SENT);
    localparam logic [1:0] SEL_IDENT = 2'h1;
    localparam logic ID_OVERFLOW = (ID_OCTETS > ID_FLAG_MAX);
    // Bit positions in header octet 1.
    localparam int B1_ABSENT = 0;
    localparam int B1_NOT_READY = 1;
    localparam int B1_CFG_FAULT = 2;
    localparam int B1_EXT_DIAG = 3;
    localparam int B1_NOT_SUPP = 4;
    localparam int B1_INVALID = 5;
    localparam int B1_PRM_FAULT = 6;
    // Bit positions in header octets 2 and 3.
    localparam int B2_PRM_REQ = 0;
    localparam int B2_STAT_DIAG = 1;
    localparam int B2_ALWAYS_ONE = 2;
    localparam int B2_WD_ON = 3;
    localparam int B2_FREEZE = 4;
    localparam int B2_SYNC = 5;
    localparam int B2_DEACT = 7;
    localparam int B3_OVERFLOW = 7;
    // Master address before any parameterisation.
    localparam logic [7:0] MASTER_NONE = 8'h00_FF;
    // Device identification; the value is arbitrary.
    localparam logic [15:0] IDENT_NUMBER = 16'h5A_3C;
    // Master side: answer timeout and receive buffer.
    localparam int CLK_NS = 8;
    localparam int TIMEOUT_NS = 1000;
    localparam int TIMEOUT_CYC = TIMEOUT_NS / CLK_NS;
    localparam int RX_DEPTH = 16;
    // Master register map, byte addresses.
    localparam logic [7:0] REG_CTRL = 8'h00_00;
    localparam logic [7:0] REG_STATUS = 8'h00_04;
    localparam logic [7:0] REG_RXBUF = 8'h00_40;
    localparam logic [3:0] CTRL_RESET = 4'h0_0;
endpackage
`default_nettype wire

// ### logic/dsd_link_if.sv
// Purpose: Logic-level link between the diagnostic slave and the polling master.
// Assumes: Both ends on the same clock; every signal but the octet stream is a one-cycle pulse.
// Notes: The master always accepts octets, so the stream has no ready.
`default_nettype none
interface dsd_link_if;
    logic dx_req;
    logic dx_rsp;
    logic dx_diag_flag;
    logic diag_req;
    logic diag_valid;
    logic [7:0] diag_data;
    logic diag_last;
    modport dev (input dx_req, diag_req,
                 output dx_rsp, dx_diag_flag, diag_valid, diag_data, diag_last);
    modport mst (output dx_req, diag_req,
                 input dx_rsp, dx_diag_flag, diag_valid, diag_data, diag_last);
endinterface
`default_nettype wire

// ### logic/dsd_octet_ser.sv
// Purpose: Sends a captured frame one octet per clock.
// Assumes: A start is not given while a frame is being sent.
// Notes: The frame is copied at start so later input changes do not tear it.
`default_nettype none
module dsd_octet_ser (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [dsd_pkg::FRAME_LEN-1:0][7:0] frame,
    output logic busy,
    output logic valid,
    output logic [7:0] data,
    output logic last
);
    import dsd_pkg::*;
    logic [FRAME_LEN-1:0][7:0] buf_reg;
    logic [7:0] idx_reg;
    logic run_reg;

    // Capture the frame and walk the index through it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_reg <= 1'b0;
            idx_reg <= 8'h00_00;
            buf_reg <= '0;
        end else if (start && !run_reg) begin
            run_reg <= 1'b1;
            idx_reg <= 8'h00_00;
            buf_reg <= frame;
        end else if (run_reg) begin
            idx_reg <= idx_reg + 8'h00_01;
            if (idx_reg == 8'(FRAME_LEN - 1)) begin
                run_reg <= 1'b0;
            end
        end
    end

    // Registered octet outputs, one cycle behind the index.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            valid <= 1'b0;
            data <= 8'h00_00;
            last <= 1'b0;
        end else begin
            valid <= run_reg;
            data <= run_reg ? buf_reg[idx_reg[4:0]] : 8'h00_00;
            last <= run_reg && (idx_reg == 8'(FRAME_LEN - 1));
        end
    end

    assign busy = run_reg;
endmodule
`default_nettype wire

// ### logic/dsd_slave_end.sv
// Purpose: Diagnostic responder of a fieldbus slave encoder.
// Assumes: Status inputs come from logic on the same clock.
// Notes: Answers a data-exchange poll in one cycle and streams the frame.
`default_nettype none
module dsd_slave_end (
    input wire logic clk,
    input wire logic rst_n,
    dsd_link_if.dev link,
    input wire logic in_data_exchange,
    input wire logic cfg_fault,
    input wire logic serious_error,
    input wire logic not_supported,
    input wire logic prm_fault,
    input wire logic prm_done,
    input wire logic [7:0] prm_master_addr,
    input wire logic wd_on,
    input wire logic freeze_mode,
    input wire logic sync_mode,
    input wire logic static_diag,
    input wire logic telegram_diag,
    output logic diag_pending,
    output logic sending
);
    import dsd_pkg::*;

    logic parameterised_reg;
    logic [7:0] master_addr_reg;
    logic pending_reg;
    logic pending_next;
    logic [7:0] oct1;
    logic [7:0] oct2;
    logic [7:0] oct3;
    logic [MOD_COUNT-1:0] mod_diag;
    logic [ID_SENT-1:0][7:0] id_flags;
    logic [FRAME_LEN-1:0][7:0] frame;
    logic [7:0] sent1_reg;
    logic [7:0] sent2_reg;
    logic [MOD_COUNT-1:0] sent_mod_reg;
    logic changed;
    logic diag_take;
    logic ser_busy;
    logic dx_rsp_reg;
    logic dx_flag_reg;

    // The encoder is not modular: the chosen telegram format is the one
    // virtual module, always placed in the only slot.
    assign mod_diag[0] = telegram_diag;

    // Parameterisation state and the address of the master that did it.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            parameterised_reg <= 1'b0;
            master_addr_reg <= MASTER_NONE;
        end else if (prm_done) begin
            parameterised_reg <= 1'b1;
            master_addr_reg <= prm_master_addr;
        end
    end

    // Header octet 1: slave-owned flags; absent and invalid stay zero
    // because only the master can know them.
    always_comb begin
        oct1 = 8'h00_00;
        oct1[B1_NOT_READY] = !in_data_exchange;
        oct1[B1_CFG_FAULT] = cfg_fault;
        oct1[B1_EXT_DIAG] = serious_error;
        oct1[B1_NOT_SUPP] = not_supported;
        oct1[B1_PRM_FAULT] = prm_fault;
        oct1[B1_ABSENT] = 1'b0;
        oct1[B1_INVALID] = 1'b0;
    end

    // Header octet 2: station state and active modes.
    always_comb begin
        oct2 = 8'h00_00;
        oct2[B2_PRM_REQ] = !parameterised_reg;
        oct2[B2_STAT_DIAG] = static_diag;
        oct2[B2_ALWAYS_ONE] = 1'b1;
        oct2[B2_WD_ON] = wd_on;
        oct2[B2_FREEZE] = freeze_mode;
        oct2[B2_SYNC] = sync_mode;
        oct2[B2_DEACT] = 1'b0;
    end

    // Header octet 3: only the overflow bit; the rest is reserved as zero.
    // Overflow can only arise if the module count outgrows the block limit.
    always_comb begin
        oct3 = 8'h00_00;
        oct3[B3_OVERFLOW] = ID_OVERFLOW;
    end

    // Module flags packed low bit first, one bit per configured module.
    // Modules beyond the block limit are dropped and raise overflow.
    genvar gi;
    generate
        for (gi = 0; gi < ID_SENT * 8; gi++) begin : g_flag
            if (gi < MOD_COUNT) begin : g_used
                assign id_flags[gi / 8][gi % 8] = mod_diag[gi];
            end else begin : g_pad
                assign id_flags[gi / 8][gi % 8] = 1'b0;
            end
        end
    endgenerate

    // Frame: six fixed octets, then the identifier-related block.
    always_comb begin
        frame = '0;
        frame[0] = oct1;
        frame[1] = oct2;
        frame[2] = oct3;
        frame[3] = master_addr_reg;
        frame[4] = IDENT_NUMBER[15:8];
        frame[5] = IDENT_NUMBER[7:0];
        frame[HDR_LEN] = {SEL_IDENT, ID_BLOCK_LEN};
        for (int i = 0; i < ID_SENT; i++) begin
            frame[HDR_LEN + 1 + i] = id_flags[i];
        end
    end

    // A request that lands while a frame is still going out is ignored;
    // the master waits for last before asking again.
    assign diag_take = link.diag_req && !ser_busy;

    // Fresh data means header octet 1 or 2 or a module flag differs from what was last sent.
    // Static diagnosis keeps the flag up so the master keeps asking.
    assign changed = (oct1 != sent1_reg) || (oct2 != sent2_reg)
                     || (mod_diag != sent_mod_reg) || static_diag;

    // A take clears the flag; the snapshot keeps what went out, so a change
    // at the take edge is still seen one cycle later. Static diagnosis wins.
    always_comb begin
        pending_next = pending_reg;
        if (diag_take) begin
            pending_next = 1'b0;
        end
        if (changed && !diag_take) begin
            pending_next = 1'b1;
        end
        if (static_diag) begin
            pending_next = 1'b1;
        end
    end

    // Pending starts set so the first poll after reset invites a request.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pending_reg <= 1'b1;
        end else begin
            pending_reg <= pending_next;
        end
    end

    // Snapshot of what went out, for change detection.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sent1_reg <= 8'h00_00;
            sent2_reg <= 8'h00_00;
            sent_mod_reg <= '0;
        end else if (diag_take) begin
            sent1_reg <= oct1;
            sent2_reg <= oct2;
            sent_mod_reg <= mod_diag;
        end
    end

    // Data-exchange reply one cycle after the poll, carrying the flag.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dx_rsp_reg <= 1'b0;
            dx_flag_reg <= 1'b0;
        end else begin
            dx_rsp_reg <= link.dx_req;
            dx_flag_reg <= link.dx_req && pending_reg;
        end
    end

    dsd_octet_ser u_ser (
        .clk(clk),
        .rst_n(rst_n),
        .start(diag_take),
        .frame(frame),
        .busy(ser_busy),
        .valid(link.diag_valid),
        .data(link.diag_data),
        .last(link.diag_last)
    );

    assign link.dx_rsp = dx_rsp_reg;
    assign link.dx_diag_flag = dx_flag_reg;
    assign diag_pending = pending_reg;
    assign sending = ser_busy;
endmodule
`default_nettype wire

// ### logic/dsd_master_end.sv
// Purpose: Polling master that fetches and checks slave diagnosis.
// Assumes: Software uses the plain register port, one strobe per cycle.
// Notes: Received octets are kept with master-owned bits merged on read.
`default_nettype none
module dsd_master_end (
    input wire logic clk,
    input wire logic rst_n,
    dsd_link_if.mst link,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata
);
    import dsd_pkg::*;
    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001, ST_DX = 4'b0010, ST_DG = 4'b0100, ST_RX = 4'b1000
    } dsd_state_type;
    dsd_state_type state_reg;
    logic [3:0] ctrl_reg;
    logic [7:0] tmo_reg;
    logic [7:0] cnt_reg;
    logic [RX_DEPTH-1:0][7:0] rx_reg;
    logic absent_reg, invalid_reg, flag_seen_reg;
    logic poll_cmd, diag_cmd, auto_diag, diag_off, timeout, frame_bad;
    logic [31:0] rdata_reg;

    assign poll_cmd = wr && (addr == REG_CTRL) && wdata[0];
    assign diag_cmd = wr && (addr == REG_CTRL) && wdata[1];
    assign auto_diag = ctrl_reg[2];
    assign diag_off = ctrl_reg[3];
    assign timeout = (tmo_reg == 8'(TIMEOUT_CYC));
    // Too short, or the fixed-one bit missing, cannot be interpreted.
    // Judged on the last octet, whose own count is not yet in cnt_reg.
    assign frame_bad = (cnt_reg < 8'(HDR_LEN - 1)) || !rx_reg[1][B2_ALWAYS_ONE];

    // Kept settings: auto diagnosis and diagnosis switched off.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr && addr == REG_CTRL) begin
            ctrl_reg <= {wdata[3:2], 2'b00};
        end
    end

    // Poll and diagnosis sequencing with an answer timeout.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            tmo_reg <= 8'h00_00;
        end else begin
            tmo_reg <= (state_reg == ST_IDLE) ? 8'h00_00 : tmo_reg + 8'h00_01;
            unique case (state_reg)
                ST_IDLE: begin
                    if (diag_cmd && !diag_off) begin
                        state_reg <= ST_DG;
                    end else if (poll_cmd) begin
                        state_reg <= ST_DX;
                    end
                end
                ST_DX: begin
                    if (link.dx_rsp && link.dx_diag_flag && auto_diag && !diag_off) begin
                        state_reg <= ST_DG;
                        tmo_reg <= 8'h00_00;
                    end else if (link.dx_rsp || timeout) begin
                        state_reg <= ST_IDLE;
                    end
                end
                ST_DG: begin
                    state_reg <= ST_RX;
                end
                ST_RX: begin
                    if (timeout) begin
                        state_reg <= ST_IDLE;
                    end else if (link.diag_valid && link.diag_last) begin
                        // Static diagnosis: ask again until it clears.
                        state_reg <= rx_reg[1][B2_STAT_DIAG] ? ST_DG : ST_IDLE;
                        tmo_reg <= 8'h00_00;
                    end
                end
            endcase
        end
    end

    // Request pulses are one cycle, made from the state.
    assign link.dx_req = (state_reg == ST_DX) && (tmo_reg == 8'h00_00);
    assign link.diag_req = (state_reg == ST_DG);

    // Octet capture; octets past the buffer are counted but not kept.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_reg <= 8'h00_00;
            rx_reg <= '0;
        end else if (state_reg == ST_DG) begin
            cnt_reg <= 8'h00_00;
        end else if (state_reg == ST_RX && link.diag_valid) begin
            if (cnt_reg < 8'(RX_DEPTH)) begin
                rx_reg[cnt_reg[3:0]] <= link.diag_data;
            end
            cnt_reg <= cnt_reg + 8'h00_01;
        end
    end

    // Master-owned results: no answer, bad answer, flag seen.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            absent_reg <= 1'b0;
            invalid_reg <= 1'b0;
            flag_seen_reg <= 1'b0;
        end else begin
            if (state_reg != ST_IDLE && timeout) begin
                absent_reg <= 1'b1;
            end else if (link.dx_rsp || link.diag_valid) begin
                absent_reg <= 1'b0;
            end
            if (state_reg == ST_RX && link.diag_valid && link.diag_last) begin
                invalid_reg <= frame_bad;
            end
            if (link.dx_rsp) begin
                flag_seen_reg <= link.dx_diag_flag;
            end
        end
    end

    // Register reads, answered in the next cycle; unmapped reads give zero.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rdata_reg <= 32'h0000_0000;
        end else if (rd) begin
            rdata_reg <= 32'h0000_0000;
            if (addr == REG_CTRL) begin
                rdata_reg[3:0] <= ctrl_reg;
            end else if (addr == REG_STATUS) begin
                rdata_reg[15:0] <= {cnt_reg, 3'b000, diag_off, invalid_reg,
                                    absent_reg, flag_seen_reg, state_reg != ST_IDLE};
            end else if (addr[7:6] == REG_RXBUF[7:6] && addr[1:0] == 2'b00) begin
                // The buffer window is decoded from the top address bits, since
                // the base and the sixty-four-byte window fill exactly 0x40 to 0x7F.
                rdata_reg[7:0] <= rx_reg[4'(addr[7:2])];
                if (addr == REG_RXBUF) begin
                    rdata_reg[B1_ABSENT] <= absent_reg;
                    rdata_reg[B1_INVALID] <= invalid_reg;
                end
                if (addr == REG_RXBUF + 8'h00_04) begin
                    rdata_reg[B2_DEACT] <= diag_off;
                end
            end
        end
    end

    assign rdata = rdata_reg;
endmodule
`default_nettype wire

// ### dv/dsd_link_sva.sv
// Purpose: Link checker for the diagnostic responder and its master.
// Assumes: One clock, synchronous active-low reset.
// Notes: The octet index counts from zero within a frame.
`default_nettype none
module dsd_link_sva (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic dx_req,
    input wire logic dx_rsp,
    input wire logic dx_diag_flag,
    input wire logic diag_req,
    input wire logic diag_valid,
    input wire logic [7:0] diag_data,
    input wire logic diag_last
);
    import dsd_pkg::*;
    logic [2:0] idx_reg;
    logic [2:0] idx_next;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Octet index; wraps on the last octet so a short frame shows up at once.
    assign idx_next = diag_last ? 3'h0 : idx_reg + 3'h1;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            idx_reg <= 3'h0;
        end else if (diag_valid) begin
            idx_reg <= idx_next;
        end
    end

    rsp_after_poll_a: assert property (dx_req |=> dx_rsp)
        else $error("poll not answered one cycle later");
    rsp_needs_poll_a: assert property (dx_rsp |-> $past(dx_req))
        else $error("reply without poll");
    flag_with_rsp_a: assert property (dx_diag_flag |-> dx_rsp)
        else $error("pending flag outside a reply");
    frame_start_a: assert property ($rose(diag_valid) |-> $past(diag_req, 2))
        else $error("frame without request two cycles before");
    frame_len_a: assert property ($rose(diag_valid) |->
        (diag_valid && !diag_last)[*7] ##1 (diag_valid && diag_last))
        else $error("frame is not eight octets back to back");
    last_ends_a: assert property (diag_last |-> diag_valid ##1 !diag_valid)
        else $error("last marker misplaced");
    fixed_one_a: assert property (diag_valid && idx_reg == 3'h1 |->
        diag_data[2] && !diag_data[6] && !diag_data[7])
        else $error("second octet fixed bits wrong");
    third_octet_a: assert property (diag_valid && idx_reg == 3'h2 |->
        diag_data == {ID_OVERFLOW, 7'h00})
        else $error("third octet wrong");
    ident_pair_a: assert property (diag_valid && idx_reg == 3'h4 |->
        diag_data == IDENT_NUMBER[15:8] ##1 diag_data == IDENT_NUMBER[7:0])
        else $error("identification octets wrong");
    block_head_a: assert property (diag_valid && idx_reg == 3'h6 |->
        diag_data == {SEL_IDENT, ID_BLOCK_LEN} && diag_data[5:0] >= 6'h02)
        else $error("block header octet wrong");
    module_bits_a: assert property (diag_valid && idx_reg == 3'h7 |->
        diag_data[7:1] == 7'h00 && diag_last)
        else $error("module flag octet wrong");
endmodule
`default_nettype wire

// ### dv/dp_slave_diag_response_test.sv
// Purpose: Self-checking bench joining the slave responder and master.
// Assumes: Both ends on one 125 MHz clock.
// Notes: Octet 1 bit 7 is masked; its meaning is left to the slave.
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module dp_slave_diag_response_test;
    timeunit 1ns;
    timeprecision 1ps;
    import dsd_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic in_dx, cfg_f, ser_e, n_sup, prm_f, prm_done, wd, frz, syn, tdiag, stat;
    logic [7:0] prm_a, addr;
    logic [31:0] wdata, rdata, r;
    logic wr, rd, rd_d, prmd, f;
    logic [15:0] n;
    int n_errors = 0;
    int compares = 0;
    logic [15:0] fq[$];
    logic [31:0] rq[$];
    logic flq[$];

    dsd_link_if link ();
    dsd_slave_end u_dsd_slave_end (.clk(clk), .rst_n(rst_n), .link(link.dev),
        .in_data_exchange(in_dx), .cfg_fault(cfg_f), .serious_error(ser_e),
        .not_supported(n_sup), .prm_fault(prm_f), .prm_done(prm_done),
        .prm_master_addr(prm_a), .wd_on(wd), .freeze_mode(frz), .sync_mode(syn),
        .static_diag(stat), .telegram_diag(tdiag), .diag_pending(), .sending());
    dsd_master_end u_dsd_master_end (.clk(clk), .rst_n(rst_n), .link(link.mst),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    dsd_link_sva u_dsd_link_sva (.clk(clk), .rst_n(rst_n), .dx_req(link.dx_req),
        .dx_rsp(link.dx_rsp), .dx_diag_flag(link.dx_diag_flag), .diag_req(link.diag_req),
        .diag_valid(link.diag_valid), .diag_data(link.diag_data),
        .diag_last(link.diag_last));

    // Free-running system clock.
    always #4 clk = ~clk;

    // Every result takes the oldest note; an octet with no note is a mismatch.
    always @(posedge clk) begin
        rd_d <= rd;
        if (link.diag_valid && fq.size() == 0) begin
            n_errors++;
            $display("Error octet expected none seen %h", link.diag_data);
        end else if (link.diag_valid) begin
            n = fq.pop_front();
            `CHK("octet", n[7:0], link.diag_data & n[15:8])
        end
        if (rd_d) begin
            r = rq.pop_front();
            `CHK("rdata", r, rdata)
        end
        if (link.dx_rsp) begin
            f = flq.pop_front();
            `CHK("pending flag", f, link.dx_diag_flag)
        end
    end

    task automatic stop_test();
        $display("Comparisons %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        rq.push_back(e);
        @(posedge clk);
        rd <= 1'b0;
    endtask

    // Bounded wait until every note has been matched.
    task automatic wait_empty();
        int i;
        for (i = 0; i < 60 && fq.size() + flq.size() + rq.size() != 0; i++) begin
            @(posedge clk);
        end
        if (i == 60) begin
            n_errors++;
            stop_test();
        end
    endtask

    // Expected frame from the status now applied; mask in the upper byte.
    task automatic note_frame();
        fq.push_back({8'h7F, 1'b0, prm_f, 1'b0, n_sup, ser_e, cfg_f, !in_dx, 1'b0});
        fq.push_back({8'hFF, 2'b00, syn, frz, wd, 1'b1, stat, !prmd});
        fq.push_back({8'hFF, ID_OVERFLOW, 7'h00});
        fq.push_back({8'hFF, prmd ? prm_a : MASTER_NONE});
        fq.push_back({8'hFF, IDENT_NUMBER[15:8]});
        fq.push_back({8'hFF, IDENT_NUMBER[7:0]});
        fq.push_back({8'hFF, SEL_IDENT, ID_BLOCK_LEN});
        fq.push_back({8'hFF, 7'h00, tdiag});
    endtask

    initial begin
        {in_dx, cfg_f, ser_e, n_sup, prm_f, prm_done, wd, frz, syn, tdiag} = '0;
        {wr, rd, prmd, stat} = '0;
        prm_a = 8'h00;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        void'($urandom(32'hb0e0_3b3f));
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        // Straight out of reset the slave has news to report.
        flq.push_back(1'b1);
        wr_reg(REG_CTRL, 32'h0000_0001);
        wait_empty();
        // Random status per frame; parameterisation arrives on the third pass.
        for (int k = 0; k < 6; k++) begin
            {in_dx, cfg_f, ser_e, n_sup, prm_f, wd, frz, syn, tdiag} <= 9'($urandom);
            if (k == 2) begin
                prm_a <= 8'($urandom);
                prm_done <= 1'b1;
                prmd <= 1'b1;
                @(posedge clk);
                prm_done <= 1'b0;
            end
            @(posedge clk);
            note_frame();
            wr_reg(REG_CTRL, 32'h0000_0002);
            wait_empty();
        end
        // Nothing changed since the last frame, so no news.
        flq.push_back(1'b0);
        wr_reg(REG_CTRL, 32'h0000_0001);
        wait_empty();
        // A module flag change is news; auto mode then fetches the frame.
        tdiag <= ~tdiag;
        @(posedge clk);
        flq.push_back(1'b1);
        note_frame();
        wr_reg(REG_CTRL, 32'h0000_0005);
        wait_empty();
        rd_reg(REG_CTRL, 32'h0000_0004);
        // Static diagnosis: the master asks again; clearing it mid-frame
        // leaves exactly one more frame, which shows the bit cleared.
        stat <= 1'b1;
        @(posedge clk);
        note_frame();
        wr_reg(REG_CTRL, 32'h0000_0002);
        for (int j = 0; j < 40 && !link.diag_valid; j++) begin
            @(posedge clk);
        end
        stat <= 1'b0;
        @(posedge clk);
        note_frame();
        wait_empty();
        // Diagnosis off first; a later request must then bring no frame.
        wr_reg(REG_CTRL, 32'h0000_0008);
        wr_reg(REG_CTRL, 32'h0000_000A);
        repeat (20) @(posedge clk);
        rd_reg(REG_STATUS, 32'h0000_0812);
        rd_reg(REG_RXBUF + 8'h04, {24'h00_0000, 2'b10, syn, frz, wd, 1'b1, 1'b0, !prmd});
        rd_reg(REG_RXBUF + 8'h0C, {24'h00_0000, prmd ? prm_a : MASTER_NONE});
        rd_reg(8'h80, 32'h0000_0000);
        wait_empty();
        stop_test();
    end
endmodule
`default_nettype wire
